/* spl_map.svh */
// constants for the sample to lane packer
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH
`define SPL_SAMP_W 9
`define SPL_SAMPS_PER_CH 16
`define SPL_CH_BITS 144
`define SPL_NUM_CH 4
`define SPL_NUM_LANES 8
`define SPL_LANE_W 40
`define SPL_MODE_W 5
`define SPL_MODE_13 5'h0d
`define SPL_MODE_14 5'h0e
`define SPL_MODE_15 5'h0f
`define SPL_PAD66_W 16
`endif

/* spl_pkg.sv */
// types shared by the sample to lane packer
`default_nettype none
package spl_pkg;
    typedef logic [8:0] spl_samp_t;
    typedef logic [39:0] spl_lane_t;
    typedef enum logic [1:0] {SPL_CH_SINGLE, SPL_CH_DUAL, SPL_CH_QUAD} spl_chan_e;
endpackage : spl_pkg
`default_nettype wire

/* spl_sample_store.sv */
// holding register bank for one frame of channel samples
`timescale 1ns/1ps
`default_nettype none
module spl_sample_store #(
    parameter int DATA_W = 576
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic load_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out
);
    // take a whole frame on load, hold it otherwise
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            data_out <= '0;
        else if (load_in)
            data_out <= data_in;
    end
endmodule : spl_sample_store
`default_nettype wire

/* spl_lane_packer.sv */
// packs 9-bit channel samples into lane frames for link modes 13, 14 and 15
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.svh"
// Behaviour
// - mode 13: 8B/10B, 8 or 4 lanes, dual/single
// - mode 13: sample then one zero, four slots
// - mode 13: lane k carries samples k%4, k%4+4, k%4+8, k%4+12 of channel k/4
// - mode 14: 64B/66B, 8, 4 or 2 lanes
// - mode 14: sample then three zeros, two slots
// - mode 14: lane pairs per channel A to D
// - mode 14: even lane 0,2; odd lane 1,3
// - mode 15: 64B/66B, 8 or 4 lanes, dual/single
module spl_lane_packer
    import spl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic frame_valid_in,
    input wire logic [`SPL_MODE_W-1:0] link_mode_select_in,
    input wire logic [1:0] chan_count_in,
    input wire logic [`SPL_CH_BITS-1:0] chan_a_in,
    input wire logic [`SPL_CH_BITS-1:0] chan_b_in,
    input wire logic [`SPL_CH_BITS-1:0] chan_c_in,
    input wire logic [`SPL_CH_BITS-1:0] chan_d_in,
    output logic [`SPL_NUM_LANES*`SPL_LANE_W-1:0] lane_data_out,
    output logic [`SPL_NUM_LANES-1:0] lane_valid_out,
    output logic frame_valid_out,
    output logic mode_err_out
);
    // sample j of a channel bus, sample 0 in the low bits
    function automatic spl_samp_t samp_at(input logic [`SPL_CH_BITS-1:0] bus, input int idx);
        samp_at = bus[idx*`SPL_SAMP_W +: `SPL_SAMP_W];
    endfunction : samp_at

    // 10-bit slot: sample msb first then one zero
    function automatic logic [9:0] slot10(input spl_samp_t s);
        slot10 = {s, 1'b0};
    endfunction : slot10

    // 12-bit slot: sample msb first then three zeros
    function automatic logic [11:0] slot12(input spl_samp_t s);
        slot12 = {s, 3'h0};
    endfunction : slot12

    logic [`SPL_NUM_CH*`SPL_CH_BITS-1:0] store_q;
    logic [`SPL_CH_BITS-1:0] chan_q [`SPL_NUM_CH];
    logic [`SPL_MODE_W-1:0] mode_reg;
    spl_chan_e nch_reg;
    logic cap_valid_reg;
    logic [`SPL_MODE_W-1:0] out_mode_reg;
    spl_chan_e out_nch_reg;

    // frame samples are held while the lanes are built
    spl_sample_store #(
        .DATA_W(`SPL_NUM_CH*`SPL_CH_BITS)
    ) u_store (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .load_in(frame_valid_in),
        .data_in({chan_d_in, chan_c_in, chan_b_in, chan_a_in}),
        .data_out(store_q)
    );

    // configuration is taken together with the frame it applies to
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_reg <= '0;
            nch_reg <= SPL_CH_SINGLE;
            cap_valid_reg <= 1'b0;
        end
        else
        begin
            cap_valid_reg <= frame_valid_in;
            if (frame_valid_in)
            begin
                mode_reg <= link_mode_select_in;
                nch_reg <= spl_chan_e'(chan_count_in);
            end
        end
    end

    // mode decode and legality of the mode against the channel count
    wire is_m13 = (mode_reg == `SPL_MODE_13);
    wire is_m14 = (mode_reg == `SPL_MODE_14);
    wire is_m15 = (mode_reg == `SPL_MODE_15);
    wire is_dual = (nch_reg == SPL_CH_DUAL);
    wire is_quad = (nch_reg == SPL_CH_QUAD);
    wire no_quad_mode = is_m13 || is_m15;
    wire mode_ok = (is_m14 || (no_quad_mode && !is_quad)) && (nch_reg != 2'h3);

    logic [`SPL_LANE_W-1:0] lane_word [`SPL_NUM_LANES];
    logic [`SPL_NUM_LANES-1:0] lane_en;
    logic [`SPL_NUM_LANES*`SPL_LANE_W-1:0] lane_data_next;

    // per-lane slot layout for each mode
    generate
        for (genvar c = 0; c < `SPL_NUM_CH; c++)
        begin : g_ch
            assign chan_q[c] = store_q[c*`SPL_CH_BITS +: `SPL_CH_BITS];
        end
        for (genvar k = 0; k < `SPL_NUM_LANES; k++)
        begin : g_lane
            localparam int C4 = k / 4;
            localparam int B4 = k % 4;
            localparam int C2 = k / 2;
            localparam int P2 = k % 2;
            wire [`SPL_LANE_W-1:0] w13 = {slot10(samp_at(chan_q[C4], B4)),
                slot10(samp_at(chan_q[C4], B4 + 4)),
                slot10(samp_at(chan_q[C4], B4 + 8)),
                slot10(samp_at(chan_q[C4], B4 + 12))};
            wire [`SPL_LANE_W-1:0] w14 = {{`SPL_PAD66_W{1'b0}},
                slot12(samp_at(chan_q[C2], P2)),
                slot12(samp_at(chan_q[C2], P2 + 2))};
            wire [`SPL_LANE_W-1:0] w15 = {{`SPL_PAD66_W{1'b0}},
                slot12(samp_at(chan_q[C4], B4)),
                slot12(samp_at(chan_q[C4], B4 + 4))};
            assign lane_en[k] = mode_ok && (no_quad_mode ? (k < 4 || is_dual)
                : (k < 2 || (k < 4 && !(nch_reg == SPL_CH_SINGLE)) || is_quad));
            assign lane_word[k] = is_m13 ? w13 : (is_m14 ? w14 : w15);
            assign lane_data_next[k*`SPL_LANE_W +: `SPL_LANE_W] = lane_en[k] ? lane_word[k] : '0;
        end
    endgenerate

    // output stage, every output straight from a flop
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            lane_data_out <= '0;
            lane_valid_out <= '0;
            frame_valid_out <= 1'b0;
            mode_err_out <= 1'b0;
            out_mode_reg <= '0;
            out_nch_reg <= SPL_CH_SINGLE;
        end
        else
        begin
            frame_valid_out <= cap_valid_reg;
            if (cap_valid_reg)
            begin
                lane_data_out <= lane_data_next;
                lane_valid_out <= lane_en;
                mode_err_out <= !mode_ok;
                out_mode_reg <= mode_reg;
                out_nch_reg <= nch_reg;
            end
        end
    end

    wire out_ok = frame_valid_out && !mode_err_out;

    a_m13_lanes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_13) |-> lane_valid_out == (out_nch_reg == SPL_CH_DUAL ? 8'hff : 8'h0f))
        else $error("mode 13 lane count wrong");

    a_m13_slot_pack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_13) |-> (lane_data_out[39:31] == $past(store_q[8:0])
        && lane_data_out[30] == 1'b0 && lane_data_out[0] == 1'b0))
        else $error("mode 13 slot packing wrong");

    a_m13_lane_order: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_13) |-> lane_data_out[40+29:40+21] == $past(store_q[5*9 +: 9]))
        else $error("mode 13 sample order wrong");

    a_m14_lanes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_14) |-> lane_valid_out ==
        (out_nch_reg == SPL_CH_QUAD ? 8'hff : (out_nch_reg == SPL_CH_DUAL ? 8'h0f : 8'h03)))
        else $error("mode 14 lane count wrong");

    a_m14_pad_bits: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_14) |-> (lane_data_out[39:24] == 16'h0000
        && lane_data_out[14:12] == 3'h0 && lane_data_out[2:0] == 3'h0))
        else $error("mode 14 padding wrong");

    a_m14_chan_pair: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_14 && out_nch_reg != SPL_CH_SINGLE)
        |-> lane_data_out[80+23:80+15] == $past(store_q[144 +: 9]))
        else $error("mode 14 channel b lane wrong");

    a_m14_odd_lane: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_14) |-> lane_data_out[40+11:40+3] == $past(store_q[3*9 +: 9]))
        else $error("mode 14 odd lane wrong");

    a_m15_lanes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_15) |-> (lane_valid_out == (out_nch_reg == SPL_CH_DUAL ? 8'hff : 8'h0f)
        && lane_data_out[23:15] == $past(store_q[8:0])))
        else $error("mode 15 lanes wrong");

    a_absent_lanes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        frame_valid_out |-> (lane_valid_out[7] || lane_data_out[7*40 +: 40] == 40'h0)
        && (lane_valid_out[4] || lane_data_out[4*40 +: 40] == 40'h0)
        && (lane_valid_out[2] || lane_data_out[2*40 +: 40] == 40'h0))
        else $error("absent lane carries data");

    a_err_lanes_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_valid_out && mode_err_out) |-> (lane_valid_out == 8'h00 && lane_data_out == '0))
        else $error("illegal frame lanes not empty");

    a_m13_quad_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_valid_out && out_mode_reg == `SPL_MODE_13 && out_nch_reg == SPL_CH_QUAD) |-> mode_err_out)
        else $error("mode 13 accepted on quad");

    a_m15_quad_err: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_valid_out && out_mode_reg == `SPL_MODE_15 && out_nch_reg == SPL_CH_QUAD) |-> mode_err_out)
        else $error("mode 15 accepted on quad");

    a_m13_dual_lane: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_13 && out_nch_reg == SPL_CH_DUAL)
        |-> lane_data_out[319:311] == $past(store_q[144 + 3*9 +: 9]))
        else $error("mode 13 lane 7 sample wrong");

    a_m14_quad_lane: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (out_ok && out_mode_reg == `SPL_MODE_14 && out_nch_reg == SPL_CH_QUAD)
        |-> lane_data_out[6*40+23:6*40+15] == $past(store_q[3*144 +: 9]))
        else $error("mode 14 channel d lane wrong");
endmodule : spl_lane_packer
`default_nettype wire

/* spl_rx_model.sv */
// receiver model that unpacks lane frames and checks the padding
`timescale 1ns/1ps
`default_nettype none
module spl_rx_model (
    input wire logic [4:0] mode_in,
    input wire logic [319:0] lane_data_in,
    output logic pad_ok_out,
    output logic [8:0] rx_a0_out
);
    logic [319:0] pad_mask;
    // padding positions per lane for the active link mode
    always_comb
    begin
        pad_mask = '0;
        for (int k = 0; k < 8; k++)
            pad_mask[40 * k +: 40] = (mode_in == 5'h0d) ? 40'h0040100401 : 40'hffff007007;
    end
    // receiver discards padding and picks channel a sample 0 from lane 0
    assign pad_ok_out = ((lane_data_in & pad_mask) == '0);
    assign rx_a0_out = (mode_in == 5'h0d) ? lane_data_in[39:31] : lane_data_in[23:15];
endmodule : spl_rx_model
`default_nettype wire

/* sample_to_lane_packer_tb.sv */
// self-checking bench for the sample to lane packer
`timescale 1ns/1ps
`default_nettype none
module sample_to_lane_packer_tb;
    logic clk_in, rst_b_in, fv_in, fv_out, err_out, pad_ok;
    logic [4:0] mode;
    logic [1:0] cnt;
    logic [143:0] ca, cb, cc, cd;
    logic [319:0] lanes;
    logic [7:0] lv;
    logic [8:0] rx_a0;
    int bad_count = 0;
    int n_compared = 0;
    spl_lane_packer DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .frame_valid_in(fv_in), .link_mode_select_in(mode),
        .chan_count_in(cnt), .chan_a_in(ca), .chan_b_in(cb), .chan_c_in(cc), .chan_d_in(cd),
        .lane_data_out(lanes), .lane_valid_out(lv), .frame_valid_out(fv_out), .mode_err_out(err_out));
    spl_rx_model rx (.mode_in(mode), .lane_data_in(lanes), .pad_ok_out(pad_ok), .rx_a0_out(rx_a0));
    // distinct sample value per channel and index
    function automatic logic [8:0] smp(int c, int j);
        return 9'(c * 128 + j * 8 + 3);
    endfunction : smp
    function automatic logic [143:0] pat(int c);
        logic [143:0] v;
        for (int j = 0; j < 16; j++)
            v[9 * j +: 9] = smp(c, j);
        return v;
    endfunction : pat
    // expected {error, lane valid, lanes} for a mode and channel count
    function automatic logic [328:0] expect_out(logic [4:0] m, logic [1:0] n);
        logic [328:0] e;
        int nch, ch, base, step, slots, w, top;
        e = '0;
        nch = (n == 2'd0) ? 1 : (n == 2'd1) ? 2 : 4;
        e[328] = (n == 2'd3) || !(m inside {5'h0d, 5'h0e, 5'h0f}) || (m != 5'h0e && nch == 4);
        if (e[328])
            return e;
        step = (m == 5'h0e) ? 2 : 4;
        slots = (m == 5'h0d) ? 4 : 2;
        w = (m == 5'h0d) ? 10 : 12;
        top = (m == 5'h0d) ? 39 : 23;
        for (int k = 0; k < 8; k++)
        begin
            ch = k / step;
            base = k % step;
            e[320 + k] = (ch < nch);
            for (int s = 0; s < slots && ch < nch; s++)
                e = e | (329'(smp(ch, base + step * s)) << (40 * k + top - w * s - 8));
        end
        return e;
    endfunction : expect_out
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic compare(logic [328:0] got, logic [328:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    // bounded wait for the output pulse, returns the edges waited after the first
    task automatic wait_out(output int i);
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_in);
            #1;
            if (fv_out === 1'b1)
                return;
        end
        bad_count++;
        give_verdict();
    endtask : wait_out
    task automatic check_out(logic [4:0] m, logic [1:0] n);
        logic [328:0] e;
        e = expect_out(m, n);
        compare({err_out, lv, lanes}, e);
        compare(329'(pad_ok), 329'(1));
        if (!e[328])
            compare(329'(rx_a0), 329'(smp(0, 0)));
    endtask : check_out
    // one frame with latency check
    task automatic send(logic [4:0] m, logic [1:0] n);
        int i;
        @(posedge clk_in);
        fv_in <= 1'b1;
        mode <= m;
        cnt <= n;
        {cd, cc, cb, ca} <= {pat(3), pat(2), pat(1), pat(0)};
        @(posedge clk_in);
        fv_in <= 1'b0;
        {cd, cc, cb, ca} <= '0; // inputs move after capture, the store must hold
        wait_out(i);
        compare(329'(i), 329'(0));
        check_out(m, n);
    endtask : send
    task automatic t_mode13();
        send(5'h0d, 2'd1);
        send(5'h0d, 2'd0);
    endtask : t_mode13
    task automatic t_mode14();
        for (int n = 0; n < 3; n++)
            send(5'h0e, 2'(n));
    endtask : t_mode14
    task automatic t_mode15();
        send(5'h0f, 2'd1);
        send(5'h0f, 2'd0);
    endtask : t_mode15
    task automatic t_illegal();
        send(5'h0d, 2'd2);
        send(5'h0f, 2'd2);
        send(5'h0e, 2'd3);
        send(5'h0c, 2'd1);
        send(5'h10, 2'd0);
    endtask : t_illegal
    // two frames on consecutive edges, each shown for one cycle
    task automatic t_back_to_back();
        @(posedge clk_in);
        fv_in <= 1'b1;
        mode <= 5'h0e;
        cnt <= 2'd2;
        {cd, cc, cb, ca} <= {pat(3), pat(2), pat(1), pat(0)};
        @(posedge clk_in);
        mode <= 5'h0d;
        cnt <= 2'd0;
        @(posedge clk_in);
        fv_in <= 1'b0;
        {cd, cc, cb, ca} <= '0;
        #1;
        compare(329'(fv_out), 329'(1));
        compare({err_out, lv, lanes}, expect_out(5'h0e, 2'd2));
        @(posedge clk_in);
        #1;
        compare(329'(fv_out), 329'(1));
        check_out(5'h0d, 2'd0);
        @(posedge clk_in);
        #1;
        compare(329'(fv_out), 329'(0));
    endtask : t_back_to_back
    // reset in mid-run clears held lanes, then a frame passes again
    task automatic t_reset();
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        @(posedge clk_in);
        #1;
        compare(329'(fv_out), 329'(0));
        compare({err_out, lv, lanes}, 329'(0));
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        send(5'h0e, 2'd0);
    endtask : t_reset
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial
    begin
        {rst_b_in, fv_in, mode, cnt} = '0;
        ca = pat(0);
        cb = pat(1);
        cc = pat(2);
        cd = pat(3);
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_mode13();
        t_mode14();
        t_reset();
        t_mode15();
        t_illegal();
        t_back_to_back();
        give_verdict();
    end
endmodule : sample_to_lane_packer_tb
`default_nettype wire
